// File: design/dfl_pkg.sv
// Constants and carrier types for the forwarded-clock link transmitter
// Function
// - One link carries words one way only, from one transmitter to one receiver.
// - The transmit clock goes out beside the data so the receiver samples with it.
// - Each data line carries two parcels in every forwarded clock period, one per phase.
// - The word width, link width and buffer depth are design-time constants.
// - The user sees a write port with a full flag, the far end a read port with empty.
// - The link is at most half as wide as the word and may be narrower.
// - Each word is cut into link-wide parcels and the far end rebuilds the word.
// - User clocks on both chips are in phase with the shared source clock.
// - The system reset clears all link logic at once and holds clock alignment in reset.
// - Only the transmitter takes the system reset and passes it on to the receiver.
// - The forwarded clock is derived from the one shared source clock.
// - The forwarded clock is looped back on a feedback input to close alignment.
// - The forwarded clock runs at half the bit rate, high is phase 0, low is phase 1.
// - Link data changes at the start of each phase, one parcel per phase.
// - The valid flag is high in phase 0 only for a sending period, and always low in phase 1.
package dfl_pkg;

  localparam int WORD_W = 16;
  localparam int LINK_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PARCELS = WORD_W / LINK_W;
  localparam int LEFT_W = 3;
  localparam logic [LEFT_W-1:0] LEFT_NONE = 3'h0;
  localparam logic [LEFT_W-1:0] LEFT_ONE = 3'h1;
  localparam logic [LEFT_W-1:0] LEFT_LOAD = LEFT_W'(PARCELS - 1);
  localparam int LOCK_W = 3;
  localparam logic [LOCK_W-1:0] LOCK_EDGES = 3'h4;
  localparam int LOSS_W = 3;
  localparam logic [LOSS_W-1:0] LOSS_LIMIT = 3'h6;
  localparam int SYNC_W = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SEND = 2'h2
  } dfl_state_type;

  typedef struct packed {
    logic clk;
    logic flag;
    logic [LINK_W-1:0] data;
  } dfl_link_type;

  localparam dfl_link_type LINK_RESET = '{clk: 1'b0, flag: 1'b0, data: 4'h0};

endpackage

// File: design/dfl_fifo.sv
// Word buffer with valid/ready on both sides and registered full and empty
`timescale 1ns/10ps
`default_nettype none
module dfl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word written
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain request
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = in_valid && !full_reg;
  assign do_rd = out_ready && !empty_reg;
  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (do_wr && !do_rd) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
      full_reg <= (count_next == (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end
endmodule
`default_nettype wire

// File: design/dfl_link_tx.sv
// Transmit end of the forwarded-clock double-data-rate link
`timescale 1ns/10ps
`default_nettype none
module dfl_link_tx (
  input wire logic ref_clk, // Shared source clock, also user clock
  input wire logic resetn, // System reset, async, active low
  input wire logic wr_en, // User write strobe
  input wire logic [dfl_pkg::WORD_W-1:0] wr_data, // User word
  output logic wr_full, // Buffer full
  input wire logic link_clock_feedback, // Forwarded clock looped back
  input wire logic receiver_ready, // Far buffer has room for a word
  output logic forwarded_link_clock, // Link clock out
  output logic parcel_valid_flag, // High in phase 0 of a sending period
  output logic [dfl_pkg::LINK_W-1:0] link_data_bus, // Parcel lines
  output logic receiver_reset_forward, // Reset passed to far chip
  output logic link_locked // Feedback loop seen running
);

  // Width check at elaboration; one direction only by construction
  if (dfl_pkg::LINK_W * 2 > dfl_pkg::WORD_W) begin : g_width_bad
    $error("link wider than half the word");
  end

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [dfl_pkg::WORD_W-1:0] fifo_out_data;
  logic full_reg;

  // Buffer sized by package constants
  dfl_fifo #(
    .WIDTH(dfl_pkg::WORD_W),
    .DEPTH(dfl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .resetn(resetn),
    .in_valid(wr_en),
    .in_ready(fifo_in_ready),
    .in_data(wr_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Full comes from the buffer's own registered flag
  assign full_reg = !fifo_in_ready;
  assign wr_full = full_reg;

  // Pin synchronisers: stage 0 is read only by stage 1
  logic [dfl_pkg::SYNC_W-1:0] fb_sync_reg;
  logic [dfl_pkg::SYNC_W-1:0] rdy_sync_reg;
  logic fb_prev_reg;
  logic fb_rise;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fb_sync_reg <= '0;
      rdy_sync_reg <= '0;
      fb_prev_reg <= 1'b0;
    end else begin
      fb_sync_reg <= {fb_sync_reg[0], link_clock_feedback};
      rdy_sync_reg <= {rdy_sync_reg[0], receiver_ready};
      fb_prev_reg <= fb_sync_reg[1];
    end
  end

  assign fb_rise = fb_sync_reg[1] && !fb_prev_reg;

  // Alignment loop: lock after a few clean feedback edges, drop if they stop
  logic [dfl_pkg::LOCK_W-1:0] lock_cnt_reg;
  logic [dfl_pkg::LOSS_W-1:0] loss_cnt_reg;
  logic locked_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lock_cnt_reg <= '0;
      loss_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else if (fb_rise) begin
      loss_cnt_reg <= '0;
      if (!locked_reg) begin
        if (lock_cnt_reg == dfl_pkg::LOCK_EDGES - dfl_pkg::LOCK_W'(1)) begin
          locked_reg <= 1'b1;
        end
        lock_cnt_reg <= lock_cnt_reg + dfl_pkg::LOCK_W'(1);
      end
    end else if (loss_cnt_reg == dfl_pkg::LOSS_LIMIT) begin
      // Feedback stalled: stop sending until the loop is seen again
      locked_reg <= 1'b0;
      lock_cnt_reg <= '0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + dfl_pkg::LOSS_W'(1);
    end
  end

  assign link_locked = locked_reg;

  // Reset relay: held high through reset, released on the first edge after
  logic rst_fwd_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_fwd_reg <= 1'b1;
    end else begin
      rst_fwd_reg <= 1'b0;
    end
  end

  assign receiver_reset_forward = rst_fwd_reg;

  // Serialiser
  dfl_pkg::dfl_state_type state_reg;
  logic [dfl_pkg::WORD_W-1:0] shift_reg;
  logic [dfl_pkg::LEFT_W-1:0] left_reg;
  dfl_pkg::dfl_link_type link_reg;
  logic start;

  // A word starts only at a period boundary, so a word never splits across idle
  assign start = !link_reg.clk && (left_reg == dfl_pkg::LEFT_NONE) && fifo_out_valid
    && rdy_sync_reg[1] && locked_reg && !rst_fwd_reg;
  assign fifo_out_ready = start;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dfl_pkg::ST_IDLE;
      shift_reg <= '0;
      left_reg <= dfl_pkg::LEFT_NONE;
    end else begin
      case (state_reg)
        dfl_pkg::ST_IDLE: begin
          if (start) begin
            shift_reg <= fifo_out_data >> dfl_pkg::LINK_W;
            left_reg <= dfl_pkg::LEFT_LOAD;
            state_reg <= dfl_pkg::ST_SEND;
          end
        end
        dfl_pkg::ST_SEND: begin
          shift_reg <= shift_reg >> dfl_pkg::LINK_W;
          left_reg <= left_reg - dfl_pkg::LEFT_ONE;
          if (left_reg == dfl_pkg::LEFT_ONE) begin
            state_reg <= dfl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= dfl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Link clock is ref_clk halved: each ref_clk cycle is one phase
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link_reg <= dfl_pkg::LINK_RESET;
    end else begin
      link_reg.clk <= !link_reg.clk;
      if (!link_reg.clk) begin
        // Entering phase 0
        if (start) begin
          link_reg.flag <= 1'b1;
          link_reg.data <= fifo_out_data[dfl_pkg::LINK_W-1:0];
        end else if (left_reg != dfl_pkg::LEFT_NONE) begin
          link_reg.flag <= 1'b1;
          link_reg.data <= shift_reg[dfl_pkg::LINK_W-1:0];
        end else begin
          link_reg.flag <= 1'b0;
          link_reg.data <= '0;
        end
      end else begin
        // Entering phase 1: second parcel of the period, flag always low
        link_reg.flag <= 1'b0;
        if (state_reg == dfl_pkg::ST_SEND) begin
          link_reg.data <= shift_reg[dfl_pkg::LINK_W-1:0];
        end else begin
          link_reg.data <= '0;
        end
      end
    end
  end

  // User side runs on ref_clk itself, so it stays in phase with the source
  assign forwarded_link_clock = link_reg.clk;
  assign parcel_valid_flag = link_reg.flag;
  assign link_data_bus = link_reg.data;

  // Checks
  property p_flag_phase1;
    @(posedge ref_clk) disable iff (!resetn)
    !link_reg.clk |-> !link_reg.flag;
  endproperty
  a_flag_phase1: assert property (p_flag_phase1) else $error("flag high in phase 1");

  property p_clk_halves;
    @(posedge ref_clk) disable iff (!resetn)
    link_reg.clk |=> !link_reg.clk ##1 link_reg.clk;
  endproperty
  a_clk_halves: assert property (p_clk_halves) else $error("link clock not ref/2");

  property p_pop_sends;
    @(posedge ref_clk) disable iff (!resetn)
    fifo_out_ready |=> link_reg.clk && link_reg.flag
      && link_reg.data == $past(fifo_out_data[dfl_pkg::LINK_W-1:0]);
  endproperty
  a_pop_sends: assert property (p_pop_sends) else $error("first parcel wrong");

  property p_word_two_periods;
    @(posedge ref_clk) disable iff (!resetn)
    fifo_out_ready |=> link_reg.flag ##1 !link_reg.flag ##1 link_reg.flag ##1 !link_reg.flag;
  endproperty
  a_word_two_periods: assert property (p_word_two_periods) else $error("word not 2 periods");

  property p_last_parcel;
    @(posedge ref_clk) disable iff (!resetn)
    fifo_out_ready |=> ##3 link_reg.data
      == $past(fifo_out_data[dfl_pkg::WORD_W-1:dfl_pkg::WORD_W-dfl_pkg::LINK_W], 4);
  endproperty
  a_last_parcel: assert property (p_last_parcel) else $error("last parcel wrong");

  property p_send_needs_ready;
    @(posedge ref_clk) disable iff (!resetn)
    fifo_out_ready |-> locked_reg && rdy_sync_reg[1] && fifo_out_valid;
  endproperty
  a_send_needs_ready: assert property (p_send_needs_ready) else $error("sent without room");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!resetn)
    (link_reg.clk && !link_reg.flag) |-> link_reg.data == '0 ##1 link_reg.data == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle period not quiet");

  property p_reset_relay;
    @(posedge ref_clk) disable iff (!resetn)
    link_reg.flag |-> !rst_fwd_reg;
  endproperty
  a_reset_relay: assert property (p_reset_relay) else $error("sent under far reset");

  property p_full_holds;
    @(posedge ref_clk) disable iff (!resetn)
    (full_reg && !fifo_out_ready) |=> full_reg;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("full dropped without drain");

  property p_lock_needs_feedback;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(locked_reg) |-> $past(fb_rise);
  endproperty
  a_lock_needs_feedback: assert property (p_lock_needs_feedback) else $error("lock w/o fb");

  c_word_sent: cover property (@(posedge ref_clk) disable iff (!resetn)
    fifo_out_ready ##4 fifo_out_ready);
  c_full: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(full_reg));
  c_locked: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(locked_reg));
  c_lock_lost: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(locked_reg));

endmodule
`default_nettype wire

// File: verif/dfl_rx_model.sv
// Behavioural receiving end of the forwarded-clock link
`timescale 1ns/10ps
`default_nettype none
module dfl_rx_model (
  input wire logic ref_clk, // Receiver user clock, shared source
  input wire logic rst_fwd, // Reset relayed by the transmitter
  input wire logic link_clk, // Forwarded link clock
  input wire logic flag, // Parcel valid flag
  input wire logic [dfl_pkg::LINK_W-1:0] data, // Parcel lines
  input wire logic stall, // Bench holds the far buffer busy
  output logic ready, // Room for a whole word
  output logic word_valid, // Rebuilt word strobe
  output logic [dfl_pkg::WORD_W-1:0] word, // Rebuilt word
  output logic proto_err // Flag seen in phase 1
);
  logic [dfl_pkg::WORD_W-1:0] acc;
  int idx;

  // Held busy while in reset, so nothing is lost before release
  assign ready = !stall && !rst_fwd;

  // Same clock as the transmitter; link clock level gives the phase
  always @(posedge ref_clk) begin
    word_valid <= 1'b0;
    if (rst_fwd) begin
      idx = 0;
      proto_err <= 1'b0;
    end else begin
      if (!link_clk && flag) begin
        proto_err <= 1'b1;
      end
      if ((link_clk && flag) || (!link_clk && idx % 2 == 1)) begin
        acc[idx*dfl_pkg::LINK_W +: dfl_pkg::LINK_W] = data;
        idx = idx + 1;
        if (idx == dfl_pkg::PARCELS) begin
          word <= acc;
          word_valid <= 1'b1;
          idx = 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the link transmitter
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk;
  logic resetn;
  logic wr_en;
  logic [dfl_pkg::WORD_W-1:0] wr_data;
  logic wr_full;
  logic fb_cut;
  logic fb;
  logic stall;
  logic rx_ready;
  logic fwd_clk;
  logic flag;
  logic [dfl_pkg::LINK_W-1:0] link_data;
  logic rst_fwd;
  logic locked;
  logic rx_valid;
  logic [dfl_pkg::WORD_W-1:0] rx_word;
  logic rx_err;
  logic [31:0] seed;
  logic [dfl_pkg::WORD_W-1:0] exp_q[$];
  int error_cnt;
  int checks;
  int got;
  int g0;

  // Loop cut lets the bench starve the lock detector
  assign fb = fb_cut ? 1'b0 : fwd_clk;

  dfl_link_tx dut (.ref_clk(ref_clk), .resetn(resetn), .wr_en(wr_en), .wr_data(wr_data),
    .wr_full(wr_full), .link_clock_feedback(fb), .receiver_ready(rx_ready),
    .forwarded_link_clock(fwd_clk), .parcel_valid_flag(flag), .link_data_bus(link_data),
    .receiver_reset_forward(rst_fwd), .link_locked(locked));

  dfl_rx_model rx (.ref_clk(ref_clk), .rst_fwd(rst_fwd), .link_clk(fwd_clk), .flag(flag),
    .data(link_data), .stall(stall), .ready(rx_ready), .word_valid(rx_valid),
    .word(rx_word), .proto_err(rx_err));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      got++;
      if (exp_q.size() == 0) begin
        check("surplus word", 32'h1, 32'h0);
      end else begin
        check("word", rx_word, exp_q.pop_front());
      end
    end
  end

  // Leaves wr_en high so writes can run back to back
  task automatic put(input logic [dfl_pkg::WORD_W-1:0] w);
    @(negedge ref_clk);
    wr_en = 1'b1;
    wr_data = w;
    if (wr_full === 1'b0) begin
      exp_q.push_back(w);
    end
  endtask

  task automatic idle();
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    resetn = 1'b0;
    #1;
    check("clock in reset", fwd_clk, 32'h0);
    check("flag in reset", flag, 32'h0);
    check("data in reset", link_data, 32'h0);
    check("relay in reset", rst_fwd, 32'h1);
    check("lock in reset", locked, 32'h0);
    check("full in reset", wr_full, 32'h0);
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    exp_q.delete();
    @(posedge ref_clk);
    #1;
    check("relay release", rst_fwd, 32'h0);
    check("phase 0 first", fwd_clk, 32'h1);
    @(posedge ref_clk);
    #1;
    check("phase 1 next", fwd_clk, 32'h0);
  endtask

  task automatic wait_lock(input logic want);
    int n;
    n = 0;
    while (locked !== want && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("lock state", locked, want);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check("words left", exp_q.size(), 32'h0);
  endtask

  initial begin
    #600000;
    error_cnt++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    wr_data = 16'h0;
    fb_cut = 1'b0;
    stall = 1'b0;
    seed = 32'h7d19;
    error_cnt = 0;
    checks = 0;
    got = 0;
    do_reset();
    wait_lock(1'b1);
    $display("test reset and lock done");
    for (int i = 0; i < 80; i++) begin
      seed = xs(seed);
      put(seed[15:0]);
      stall = (seed[30:28] == 3'h0);
      if (seed[20]) begin
        idle();
      end
    end
    put(16'h0000);
    put(16'hffff);
    put(16'h8421);
    put(16'h1248);
    idle();
    stall = 1'b0;
    drain();
    $display("test random traffic done");
    // Pin inputs move off the sampling edge
    @(negedge ref_clk);
    stall = 1'b1;
    repeat (6) @(negedge ref_clk);
    g0 = got;
    for (int i = 0; i < 10; i++) begin
      put(16'ha5a0 + 16'(i));
    end
    idle();
    check("full after eight", wr_full, 32'h1);
    repeat (12) @(negedge ref_clk);
    check("nothing sent while stalled", got, g0);
    stall = 1'b0;
    drain();
    check("full after drain", wr_full, 32'h0);
    check("dropped writes", got, g0 + 8);
    $display("test fill and stall done");
    @(negedge ref_clk);
    fb_cut = 1'b1;
    wait_lock(1'b0);
    g0 = got;
    put(16'h3c3c);
    idle();
    repeat (30) @(negedge ref_clk);
    check("nothing sent unlocked", got, g0);
    fb_cut = 1'b0;
    wait_lock(1'b1);
    drain();
    $display("test loop loss done");
    put(16'h1111);
    put(16'h2222);
    idle();
    do_reset();
    wait_lock(1'b1);
    put(16'h7e81);
    idle();
    drain();
    check("phase 1 flag", rx_err, 32'h0);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
